// File: rtl/mivc_ctrl.sv
/*
 * Interrupt recognition, two-level prioritisation and vectoring logic with
 * an APB register slave and a maskable event interrupt.
 * Assumes a core that pulses instr_done at each instruction boundary and
 * return_from_interrupt when a return finishes, and that performs the
 * five-cycle call while long_subroutine_call is high. Peripheral set
 * pulses arrive on pclk; supply-ok and port-match inputs are asynchronous.
 */
`include "mivc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mivc_ctrl #(
    parameter int NSRC = `MIVC_NUM_SRC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSRC-1:0] src_set,
    input wire logic core_supply_ok,
    input wire logic battery_supply_ok,
    input wire logic port_match,
    input wire logic instr_done,
    input wire logic return_from_interrupt,
    output logic long_subroutine_call,
    output logic [15:0] vector_addr,
    output logic [4:0] vector_order,
    output logic irq
);
    import mivc_pkg::*;

    mivc_state_type state_ff, nxt_state;
    logic [NSRC-1:0] en_ff, prio_ff, pend_ff, nxt_pend;
    logic global_irq_enable_ff;
    logic [7:0] ind_addr_ff;
    logic [1:0] evt_stat_ff, evt_mask_ff, nxt_evt_stat;
    logic act_lo_ff, act_hi_ff, hold_ff;
    logic req_ff, req_hi_ff;
    logic [4:0] req_id_ff, gnt_id_ff;
    logic [2:0] call_cnt_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, irq_ff, call_ff;
    logic [15:0] vec_ff;
    logic [2:0] sup_sync_ff, sup_meta_ff;

    // Lowest order number among the set bits
    function automatic logic [4:0] mivc_first(input logic [NSRC-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // Supply and port-match levels come from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_meta_ff <= 3'h7;
            sup_sync_ff <= 3'h7;
        end else begin
            sup_meta_ff <= {~port_match, battery_supply_ok, core_supply_ok};
            sup_sync_ff <= sup_meta_ff;
        end
    end

    // Bus decode
    wire acc = psel && penable && pready_ff;
    wire wr = acc && pwrite;
    wire setup = psel && !penable && !pready_ff;
    wire wr_ie = wr && (paddr == `MIVC_OFF_IE);
    wire wr_prio = wr && (paddr == `MIVC_OFF_PRIO);
    wire wr_xen1 = wr && (paddr == `MIVC_OFF_XEN1);
    wire wr_xpr1 = wr && (paddr == `MIVC_OFF_XPR1);
    wire wr_xen2 = wr && (paddr == `MIVC_OFF_XEN2);
    wire wr_xpr2 = wr && (paddr == `MIVC_OFF_XPR2);
    wire wr_pend = wr && (paddr == `MIVC_OFF_PEND);
    wire wr_iadr = wr && (paddr == `MIVC_OFF_IND_ADDR);
    wire wr_idat = wr && (paddr == `MIVC_OFF_IND_DATA);
    wire wr_stat = wr && (paddr == `MIVC_OFF_EVT_STAT);
    wire wr_mask = wr && (paddr == `MIVC_OFF_EVT_MASK);
    wire mapped = (paddr <= `MIVC_OFF_EVT_MASK) && (paddr[1:0] == 2'h0);

    // Supply warning pends while either supply is reported not ok; the
    // flag is read-only, so only its enable or the global enable can stop vectoring
    wire warn_lvl = !(sup_sync_ff[0] && sup_sync_ff[1]);
    wire match_lvl = !sup_sync_ff[2];

    wire [NSRC-1:0] level_src = (NSRC'(warn_lvl) << `MIVC_ORD_WARN) |
        (NSRC'(match_lvl) << `MIVC_ORD_MATCH);
    wire [NSRC-1:0] eff_pend = pend_ff | level_src;

    // Eligibility and two-level arbitration, recomputed every cycle
    wire [NSRC-1:0] elig = global_irq_enable_ff ?
        (eff_pend & en_ff) : '0;
    wire [NSRC-1:0] elig_hi = elig & prio_ff;
    wire [NSRC-1:0] elig_lo = elig & ~prio_ff;
    wire can_hi = |elig_hi && !act_hi_ff;
    wire can_lo = |elig_lo && !act_hi_ff && !act_lo_ff;
    wire pick = can_hi || can_lo;
    wire [4:0] pick_id = can_hi ? mivc_first(elig_hi) :
        mivc_first(elig_lo);

    // Vector at an instruction boundary once the detect stage holds a
    // request; a just-finished return needs one more boundary first
    wire start_call = (state_ff == MIVC_CALL) ? 1'b0 :
        (req_ff && instr_done && !hold_ff &&
        !return_from_interrupt);
    wire call_end = (state_ff == MIVC_CALL) &&
        (call_cnt_ff == `MIVC_CALL_CYCLES - 3'h1);
    wire [15:0] vec_calc = `MIVC_VEC_BASE +
        16'(req_id_ff) * `MIVC_VEC_STEP;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MIVC_IDLE: begin
                if (start_call) begin
                    nxt_state = MIVC_CALL;
                end
            end
            MIVC_CALL: begin
                if (call_end) begin
                    nxt_state = MIVC_IDLE;
                end
            end
            default: begin
                nxt_state = MIVC_IDLE;
            end
        endcase
    end

    // Pending flags: software write, hardware clear on vectoring of orders 0 to 3, then
    // peripheral set, which wins over both clears
    wire [NSRC-1:0] hw_clr = start_call ?
        ((NSRC'(1) << req_id_ff) & `MIVC_HWCLR_MASK) : '0;
    wire ind_alarm = ind_addr_ff == `MIVC_IND_ALARM;
    wire ind_oscf = ind_addr_ff == `MIVC_IND_OSCF;
    wire [NSRC-1:0] ind_mask = wr_idat ?
        ((NSRC'(ind_alarm) << `MIVC_ORD_ALARM) |
        (NSRC'(ind_oscf) << `MIVC_ORD_OSCF)) : '0;
    wire [NSRC-1:0] dir_mask = wr_pend ? `MIVC_DIRECT_WR_MASK : '0;
    wire [NSRC-1:0] wmask = dir_mask | ind_mask;
    wire [NSRC-1:0] wval = wr_pend ? pwdata[NSRC-1:0] :
        {NSRC{pwdata[0]}};

    always_comb begin
        nxt_pend = (pend_ff & ~wmask) | (wval & wmask);
        nxt_pend = nxt_pend & ~hw_clr;
        nxt_pend = nxt_pend | src_set;
        nxt_pend[`MIVC_ORD_WARN] = 1'b0;
        nxt_pend[`MIVC_ORD_MATCH] = 1'b0;
    end

    // Event status: set wins over the write-one clear
    always_comb begin
        nxt_evt_stat = evt_stat_ff & ~(wr_stat ? pwdata[1:0] : 2'h0);
        nxt_evt_stat[`MIVC_EVT_CALL] = nxt_evt_stat[`MIVC_EVT_CALL] |
            start_call;
        nxt_evt_stat[`MIVC_EVT_RET] = nxt_evt_stat[`MIVC_EVT_RET] |
            return_from_interrupt;
    end

    // Direct pending view hides the indirectly held flags
    wire [NSRC-1:0] dir_view = eff_pend & ~((NSRC'(1) << `MIVC_ORD_ALARM) |
        (NSRC'(1) << `MIVC_ORD_OSCF));
    wire ind_bit = ind_alarm ? pend_ff[`MIVC_ORD_ALARM] :
        (ind_oscf ? pend_ff[`MIVC_ORD_OSCF] : 1'b0);
    wire [31:0] rd_mux =
        (paddr == `MIVC_OFF_IE) ?
            32'({global_irq_enable_ff, en_ff[`MIVC_IE_HI:`MIVC_IE_LO]}) :
        (paddr == `MIVC_OFF_PRIO) ?
            32'(prio_ff[`MIVC_IE_HI:`MIVC_IE_LO]) :
        (paddr == `MIVC_OFF_XEN1) ? 32'(en_ff[`MIVC_E1_HI:`MIVC_E1_LO]) :
        (paddr == `MIVC_OFF_XPR1) ? 32'(prio_ff[`MIVC_E1_HI:`MIVC_E1_LO]) :
        (paddr == `MIVC_OFF_XEN2) ? 32'(en_ff[`MIVC_E2_HI:`MIVC_E2_LO]) :
        (paddr == `MIVC_OFF_XPR2) ? 32'(prio_ff[`MIVC_E2_HI:`MIVC_E2_LO]) :
        (paddr == `MIVC_OFF_PEND) ? 32'(dir_view) :
        (paddr == `MIVC_OFF_IND_ADDR) ? 32'(ind_addr_ff) :
        (paddr == `MIVC_OFF_IND_DATA) ? 32'(ind_bit) :
        (paddr == `MIVC_OFF_STATE) ? 32'({req_id_ff, req_hi_ff, req_ff,
            hold_ff, act_hi_ff, act_lo_ff, state_ff}) :
        (paddr == `MIVC_OFF_EVT_STAT) ? 32'(evt_stat_ff) :
        (paddr == `MIVC_OFF_EVT_MASK) ? 32'(evt_mask_ff) : 32'h0;

    // APB slave: no wait states, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff <= setup ? rd_mux : 32'h0;
        end
    end

    // Enables and priorities; low priority after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= `MIVC_RST_EN;
            prio_ff <= `MIVC_RST_PRIO;
            global_irq_enable_ff <= 1'b0;
        end else begin
            if (wr_ie) begin
                global_irq_enable_ff <= pwdata[`MIVC_GLB_BIT];
                en_ff[`MIVC_IE_HI:`MIVC_IE_LO] <= pwdata[6:0];
            end
            if (wr_prio) prio_ff[`MIVC_IE_HI:`MIVC_IE_LO] <= pwdata[6:0];
            if (wr_xen1) en_ff[`MIVC_E1_HI:`MIVC_E1_LO] <= pwdata[7:0];
            if (wr_xpr1) prio_ff[`MIVC_E1_HI:`MIVC_E1_LO] <= pwdata[7:0];
            if (wr_xen2) en_ff[`MIVC_E2_HI:`MIVC_E2_LO] <= pwdata[3:0];
            if (wr_xpr2) prio_ff[`MIVC_E2_HI:`MIVC_E2_LO] <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= `MIVC_RST_PEND;
            ind_addr_ff <= 8'h00;
            evt_stat_ff <= 2'h0;
            evt_mask_ff <= 2'h0;
            irq_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            if (wr_iadr) ind_addr_ff <= pwdata[7:0];
            if (wr_mask) evt_mask_ff <= pwdata[1:0];
            evt_stat_ff <= nxt_evt_stat;
            irq_ff <= |(nxt_evt_stat & evt_mask_ff);
        end
    end

    // Detect stage: one cycle from a set flag to a registered request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff <= 1'b0;
            req_hi_ff <= 1'b0;
            req_id_ff <= 5'h00;
        end else begin
            req_ff <= pick && !start_call;
            req_hi_ff <= can_hi;
            req_id_ff <= pick_id;
        end
    end

    // Active levels and the post-return hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_lo_ff <= 1'b0;
            act_hi_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            if (start_call && req_hi_ff) begin
                act_hi_ff <= 1'b1;
            end else if (start_call) begin
                act_lo_ff <= 1'b1;
            end else if (return_from_interrupt && act_hi_ff) begin
                act_hi_ff <= 1'b0;
            end else if (return_from_interrupt) begin
                act_lo_ff <= 1'b0;
            end
            // Return plus the following instruction bounds the worst case
            if (return_from_interrupt) begin
                hold_ff <= 1'b1;
            end else if (instr_done) begin
                hold_ff <= 1'b0;
            end
        end
    end

    // Call sequence towards the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= MIVC_IDLE;
            call_cnt_ff <= 3'h0;
            call_ff <= 1'b0;
            vec_ff <= 16'h0000;
            gnt_id_ff <= 5'h00;
        end else begin
            state_ff <= nxt_state;
            call_cnt_ff <= (state_ff == MIVC_CALL) ?
                call_cnt_ff + 3'h1 : 3'h0;
            call_ff <= (nxt_state == MIVC_CALL);
            if (start_call) begin
                vec_ff <= vec_calc;
                gnt_id_ff <= req_id_ff;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign long_subroutine_call = call_ff;
    assign vector_addr = vec_ff;
    assign vector_order = gnt_id_ff;
    assign irq = irq_ff;
endmodule

`default_nettype wire

// File: rtl/mivc_pkg.sv
/*
 * Types shared by the interrupt vectoring block.
 * Assumes mivc_regs.svh provides the numeric constants.
 */
package mivc_pkg;
    typedef enum logic [1:0] {
        MIVC_IDLE = 2'b01,
        MIVC_CALL = 2'b10
    } mivc_state_type;
endpackage

// File: rtl/mivc_regs.svh
/*
 * Register offsets, field positions, reset values and cycle counts of the
 * interrupt recognition and vectoring block.
 * Assumes a 32-bit APB slave decode on byte addresses.
 */
`ifndef MIVC_REGS_SVH
`define MIVC_REGS_SVH

`define MIVC_OFF_IE 12'h000
`define MIVC_OFF_PRIO 12'h004
`define MIVC_OFF_XEN1 12'h008
`define MIVC_OFF_XPR1 12'h00c
`define MIVC_OFF_XEN2 12'h010
`define MIVC_OFF_XPR2 12'h014
`define MIVC_OFF_PEND 12'h018
`define MIVC_OFF_IND_ADDR 12'h01c
`define MIVC_OFF_IND_DATA 12'h020
`define MIVC_OFF_STATE 12'h024
`define MIVC_OFF_EVT_STAT 12'h028
`define MIVC_OFF_EVT_MASK 12'h02c

`define MIVC_NUM_SRC 19
`define MIVC_GLB_BIT 7
`define MIVC_IE_LO 0
`define MIVC_IE_HI 6
`define MIVC_E1_LO 7
`define MIVC_E1_HI 14
`define MIVC_E2_LO 15
`define MIVC_E2_HI 18
`define MIVC_ORD_ALARM 8
`define MIVC_ORD_WARN 15
`define MIVC_ORD_MATCH 16
`define MIVC_ORD_OSCF 17

`define MIVC_HWCLR_MASK 19'h0000f
`define MIVC_DIRECT_WR_MASK 19'h47eff
`define MIVC_IND_ALARM 8'h00
`define MIVC_IND_OSCF 8'h01

`define MIVC_RST_EN 19'h00000
`define MIVC_RST_PRIO 19'h00000
`define MIVC_RST_PEND 19'h00000
`define MIVC_EVT_CALL 0
`define MIVC_EVT_RET 1

`define MIVC_CALL_CYCLES 3'h5
`define MIVC_VEC_BASE 16'h0003
`define MIVC_VEC_STEP 16'h0008

`endif

// File: verif/mivc_core_model.sv
/* Behavioural core: single-cycle instructions and a five-cycle return.
   Assumes ret_cmd is pulsed only outside a vector call. */
`timescale 1ns/1ps
`default_nettype none
module mivc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic long_subroutine_call,
    input wire logic ret_cmd,
    output logic instr_done,
    output logic return_from_interrupt
);
    logic [2:0] ret_cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_cnt_ff <= 3'h0;
            instr_done <= 1'h0;
            return_from_interrupt <= 1'h0;
        end else if (ret_cnt_ff != 3'h0) begin
            // Return retires nothing until its last cycle
            ret_cnt_ff <= ret_cnt_ff - 3'h1;
            instr_done <= 1'h0;
            return_from_interrupt <= (ret_cnt_ff == 3'h1);
        end else begin
            // Back-to-back single-cycle instructions, none during a call
            ret_cnt_ff <= ret_cmd ? 3'h5 : 3'h0;
            instr_done <= !ret_cmd && !long_subroutine_call;
            return_from_interrupt <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// File: verif/mivc_ctrl_chk.sv
/* Port-level checks for the vectoring block.
   Assumes one clock domain; the bind follows the module. */
`timescale 1ns/1ps
`default_nettype none
module mivc_ctrl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_done,
    input wire logic return_from_interrupt,
    input wire logic long_subroutine_call,
    input wire logic [15:0] vector_addr,
    input wire logic [4:0] vector_order
);
    wire logic lsc = long_subroutine_call;
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_call_len: assert property (
        $rose(lsc) |-> lsc [*5] ##1 !lsc)
        else $error("call length is not five cycles");
    a_call_cause: assert property (
        $rose(lsc) |-> $past(instr_done) && !$past(return_from_interrupt))
        else $error("call started without an instruction boundary");
    a_vec_formula: assert property (
        $rose(lsc) |-> vector_addr == {8'h00, vector_order, 3'b011})
        else $error("vector does not match order");
    a_vec_hold: assert property (
        lsc && $past(lsc) |-> $stable(vector_addr) && $stable(vector_order))
        else $error("vector moved during call");
    a_order_range: assert property (
        $rose(lsc) |-> vector_order < 5'h13)
        else $error("granted order out of range");
    a_ret_hold: assert property (
        return_from_interrupt |-> !lsc [*3])
        else $error("call issued without one instruction after return");
    a_setup_ready: assert property (
        psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held beyond one cycle");
    a_err_map: assert property (
        pready && paddr > 12'h02c |-> pslverr)
        else $error("unmapped access without error");
    a_rdata_idle: assert property (
        !pready |-> prdata == 32'h0)
        else $error("read data outside access cycle");
endmodule
bind mivc_ctrl mivc_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_done(instr_done),
    .return_from_interrupt(return_from_interrupt),
    .long_subroutine_call(long_subroutine_call),
    .vector_addr(vector_addr), .vector_order(vector_order));
`default_nettype wire

// File: verif/tb_mivc_ctrl.sv
/* Bench for the vectoring block: APB tasks and call sequences.
   Assumes the checker bind and the core model are compiled first. */
`include "mivc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_mivc_ctrl;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, ret_cmd = 1'h0, sup_ok = 1'h1, bat_ok = 1'h1;
    logic pmatch = 1'h0, pready, pslverr, err, lsc, irq, idone, rti;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [18:0] src_set = 19'h0;
    logic [15:0] vaddr;
    logic [4:0] vord;
    int n_fail = 0;
    int check_count = 0;
    initial begin
        forever #5 pclk = ~pclk;
    end
    mivc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_set(src_set), .core_supply_ok(sup_ok),
        .battery_supply_ok(bat_ok), .port_match(pmatch),
        .instr_done(idone), .return_from_interrupt(rti),
        .long_subroutine_call(lsc), .vector_addr(vaddr),
        .vector_order(vord), .irq(irq));
    mivc_core_model core (.pclk(pclk), .presetn(presetn),
        .long_subroutine_call(lsc), .ret_cmd(ret_cmd),
        .instr_done(idone), .return_from_interrupt(rti));
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h, want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Waits for a call, compares strobe, order and vector, then lets it end
    task automatic call_is(input logic [4:0] ord, input logic [15:0] vec);
        int i;
        for (i = 0; i < 60 && lsc !== 1'h1; i++) @(posedge pclk);
        chk({10'h0, lsc, vord, vaddr}, {10'h0, 1'h1, ord, vec});
        for (i = 0; i < 9 && lsc === 1'h1; i++) @(posedge pclk);
    endtask
    task automatic quiet(input int n);
        int i;
        logic seen;
        seen = 1'h0;
        for (i = 0; i < n; i++) begin
            @(posedge pclk);
            seen = seen | lsc;
        end
        chk({31'h0, seen}, 32'h0);
    endtask
    // Ends one cycle after the return pulse so a second return is never swallowed
    task automatic ret;
        int i;
        @(posedge pclk);
        ret_cmd <= 1'h1;
        @(posedge pclk);
        ret_cmd <= 1'h0;
        for (i = 0; i < 20 && rti !== 1'h1; i++) @(posedge pclk);
        @(posedge pclk);
    endtask
    task automatic pulse(input logic [18:0] m);
        @(posedge pclk);
        src_set <= m;
        @(posedge pclk);
        src_set <= 19'h0;
    endtask
    initial begin
        #100us;
        n_fail++;
        conclude;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        for (int k = 0; k < 7; k++) begin
            apb(1'h0, 12'(4 * k), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'h0, 12'h030, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("test reset done");
        apb(1'h1, `MIVC_OFF_IE, 32'h81);
        pulse(19'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, lsc}, 32'h0);
        @(posedge pclk);
        chk({31'h0, lsc}, 32'h1);
        call_is(5'd0, 16'h0003);
        apb(1'h0, `MIVC_OFF_PEND, 32'h0);
        chk(rd, 32'h0);
        ret;
        apb(1'h1, `MIVC_OFF_IE, 32'h01);
        pulse(19'h1);
        quiet(20);
        apb(1'h1, `MIVC_OFF_IE, 32'h81);
        call_is(5'd0, 16'h0003);
        ret;
        $display("test order zero done");
        apb(1'h1, `MIVC_OFF_IE, 32'hb0);
        pulse(19'h30);
        call_is(5'd4, 16'h0023);
        apb(1'h0, `MIVC_OFF_PEND, 32'h0);
        chk(rd, 32'h30);
        ret;
        call_is(5'd4, 16'h0023);
        apb(1'h1, `MIVC_OFF_PEND, 32'h20);
        quiet(10);
        ret;
        call_is(5'd5, 16'h002b);
        apb(1'h1, `MIVC_OFF_PRIO, 32'h40);
        apb(1'h1, `MIVC_OFF_IE, 32'hf0);
        apb(1'h1, `MIVC_OFF_PEND, 32'h60);
        call_is(5'd6, 16'h0033);
        apb(1'h1, `MIVC_OFF_PEND, 32'h70);
        quiet(10);
        apb(1'h1, `MIVC_OFF_PEND, 32'h0);
        ret;
        ret;
        apb(1'h1, `MIVC_OFF_PRIO, 32'h0);
        $display("test priority done");
        apb(1'h1, `MIVC_OFF_IE, 32'h80);
        apb(1'h1, `MIVC_OFF_XEN2, 32'h1);
        sup_ok <= 1'h0;
        call_is(5'd15, 16'h007b);
        apb(1'h1, `MIVC_OFF_PEND, 32'h0);
        apb(1'h0, `MIVC_OFF_PEND, 32'h0);
        chk(rd & 32'h8000, 32'h8000);
        apb(1'h1, `MIVC_OFF_XEN2, 32'h0);
        ret;
        quiet(20);
        sup_ok <= 1'h1;
        bat_ok <= 1'h0;
        apb(1'h1, `MIVC_OFF_XEN2, 32'h1);
        call_is(5'd15, 16'h007b);
        bat_ok <= 1'h1;
        apb(1'h1, `MIVC_OFF_XEN2, 32'h2);
        ret;
        pmatch <= 1'h1;
        call_is(5'd16, 16'h0083);
        pmatch <= 1'h0;
        ret;
        pulse(19'h100);
        apb(1'h0, `MIVC_OFF_PEND, 32'h0);
        chk(rd & 32'h100, 32'h0);
        apb(1'h1, `MIVC_OFF_IND_ADDR, 32'h0);
        apb(1'h0, `MIVC_OFF_IND_DATA, 32'h0);
        chk(rd & 32'h1, 32'h1);
        $display("test supply and indirect done");
        apb(1'h1, `MIVC_OFF_EVT_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, `MIVC_OFF_EVT_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'h1, `MIVC_OFF_EVT_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'h0, `MIVC_OFF_EVT_STAT, 32'h0);
        chk(rd & 32'h1, 32'h0);
        $display("test event irq done");
        conclude;
    end
endmodule
`default_nettype wire
